// >>> hdl/bus_capture.sv
// Purpose: find host strobe edges, sample status, capture write data
// Assumes: strobe and status synchronous to clk
// Notes: the device's own strobe pulse must be masked by the caller
`timescale 1ns/1ps
`default_nettype none
module bus_capture
  import fp_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic strobeIn,
  input wire logic [3:0] statusIn,
  input wire logic [31:0] dataIn,
  input wire logic sampleAtT2,
  input wire logic t2State,
  slave_cycle_if.src cyc
);
  logic low_q, low_d, taken_q, taken_d, sampleNow;
  logic [3:0] status_q, status_d;

  always_comb begin
    low_d = !strobeIn;
    // one host variant wants status taken in T2, not at strobe fall
    sampleNow = sampleAtT2 ? (t2State && !strobeIn && !taken_q)
                           : (!strobeIn && !low_q);
    taken_d = strobeIn ? 1'b0 : (taken_q || sampleNow);
    status_d = sampleNow ? statusIn : status_q;
    cyc.start = sampleNow;
    cyc.status = status_d;
    cyc.finish = strobeIn && low_q && taken_q;
    cyc.data = dataIn;
    cyc.strobeLow = !strobeIn;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 1'b0;
      taken_q <= 1'b0;
      status_q <= 4'h0;
    end else begin
      low_q <= low_d;
      taken_q <= taken_d;
      status_q <= status_d;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/fp_exec.sv
// Purpose: opcode decode, compare and exception detection
// Assumes: operands held stable by the caller
// Notes: no arithmetic datapath; only compare and status transfer act
`timescale 1ns/1ps
`default_nettype none
module fp_exec
  import fp_port_pkg::*;
(
  input wire fmt_e fmt,
  input wire logic [15:0] opWord,
  input wire logic [63:0] gen1,
  input wire logic [63:0] gen2,
  input wire logic [31:0] fp_status_register,
  output logic illegal,
  output logic [1:0] numOps,
  output logic isDouble,
  output logic isLoadStatus,
  output logic isStoreStatus,
  output logic isCompare,
  output dest_e dest,
  output logic [2:0] cause,
  output logic trap,
  output logic equal,
  output logic greater
);
  logic [3:0] op;
  logic [2:0] op9;
  logic isFloat;

  function automatic logic isZero(input logic [63:0] v, input logic dbl);
    return dbl ? (v[62:0] == 63'h0) : (v[30:0] == 31'h0);
  endfunction

  function automatic logic isReserved(input logic [63:0] v, input logic dbl);
    return dbl ? (&v[62:52]) : (&v[30:23]);
  endfunction

  always_comb begin
    op = opWord[OPW_OP_LSB +: 4];
    op9 = opWord[OPW_OP9_LSB +: 3];
    illegal = 1'b0;
    numOps = 2'd2;
    isDouble = !opWord[OPW_F];
    isLoadStatus = 1'b0;
    isStoreStatus = 1'b0;
    isCompare = 1'b0;
    isFloat = 1'b1;
    dest = DEST_GEN2;
    case (fmt)
      FMT9: begin
        isFloat = 1'b0;
        numOps = 2'd1;
        if (op9 == OP9_LOAD_STATUS_INSTR) begin
          isLoadStatus = 1'b1;
          isDouble = 1'b0;
          dest = DEST_NONE;
        end else if (op9 == OP9_STORE_STATUS_INSTR) begin
          isStoreStatus = 1'b1;
          numOps = 2'd0;
        end
      end
      FMT11: begin
        case (op)
          OP11_DIV, OP11_ADD, OP11_SUB, OP11_MUL: numOps = 2'd2;
          OP11_NEG, OP11_ABS, OP11_MOV: numOps = 2'd1;
          OP11_CMP: begin
            isCompare = 1'b1;
            dest = DEST_NONE;
          end
          default: illegal = 1'b1;
        endcase
      end
      FMT12: begin
        case (op)
          OP12_SCALE_BY_POW2_OP: numOps = 2'd2;
          OP12_LOGB: numOps = 2'd1;
          OP12_DOT, OP12_POLY:
            dest = opWord[OPW_F] ? DEST_ACC_SINGLE : DEST_ACC_DOUBLE;
          default: illegal = 1'b1;
        endcase
      end
      default: illegal = 1'b1;
    endcase
    if (illegal) begin
      numOps = 2'd0;
      dest = DEST_NONE;
    end
    // compare on sign and magnitude; both zeros count as equal
    equal = (gen1 == gen2) || (isZero(gen1, isDouble) && isZero(gen2, isDouble));
    if (equal) begin
      greater = 1'b0;
    end else if (gen1[isDouble ? 63 : 31] != gen2[isDouble ? 63 : 31]) begin
      greater = !gen1[isDouble ? 63 : 31];
    end else if (isDouble) begin
      greater = gen1[63] ^ (gen1[62:0] > gen2[62:0]);
    end else begin
      greater = gen1[31] ^ (gen1[30:0] > gen2[30:0]);
    end
    cause = TT_NONE;
    if (illegal) begin
      cause = TT_ILLEGAL;
    end else if (isFloat && (isReserved(gen1, isDouble)
             || (numOps == 2'd2 && isReserved(gen2, isDouble)))) begin
      cause = TT_INVALID;
    end else if (fmt == FMT11 && op == OP11_DIV && isZero(gen1, isDouble)) begin
      cause = isZero(gen2, isDouble) ? TT_INVALID : TT_DIVZERO;
    end
    // underflow and inexact only trap when their enable bit is set
    trap = (cause != TT_NONE)
        && !(cause == TT_UNDERFLOW && !fp_status_register[FSR_UEN])
        && !(cause == TT_INEXACT && !fp_status_register[FSR_IEN]);
  end
endmodule
`default_nettype wire

// >>> hdl/fp_slave_coprocessor_port.sv
// Purpose: slave bus port of the floating-point coprocessor
// Assumes: host pins synchronous to clk; strobe released high between cycles
// Notes: pin enables are active low; read data follows the strobe by one clock
`timescale 1ns/1ps
`default_nettype none
module fp_slave_coprocessor_port
  import fp_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slaveStrobeIn,
  output logic slaveStrobeOut,
  output logic slaveStrobeDriveN,
  input wire logic [3:0] busStatusCode,
  input wire logic [31:0] dataIn,
  output logic [31:0] dataOut,
  output logic dataDriveN,
  output logic doneStrobeB,
  output logic statusReadRequest,
  input wire logic wideProtocol,
  input wire logic sampleAtT2,
  input wire logic t2State,
  output logic clocksStopped,
  output logic [1:0] roundMode,
  output logic [1:0] resultDest
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  slave_cycle_if cyc();

  seq_e state_q, state_d;
  fmt_e fmt_q, fmt_d;
  logic [15:0] opWord_q, opWord_d;
  logic [63:0] gen1_q, gen1_d;
  logic [63:0] gen2_q, gen2_d;
  logic opIdx_q, opIdx_d;
  logic [1:0] wordIdx_q, wordIdx_d;
  logic resIdx_q, resIdx_d;
  logic [31:0] fsr_q, fsr_d;
  logic [7:0] ssw_q, ssw_d;
  logic [1:0] dest_q, dest_d;

  logic strobeOut_q, strobeOut_d;
  logic strobeDriveN_q, strobeDriveN_d;
  logic [31:0] dataOut_q, dataOut_d;
  logic dataDriveN_q, dataDriveN_d;
  logic [1:0] doneCnt_q, doneCnt_d;
  logic doneB_q, doneB_d;
  logic status_read_request_q, status_read_request_d;
  logic [7:0] idle_q, idle_d;
  logic stopped_q, stopped_d;

  logic illegal, isDouble, isLoadStatus, isStoreStatus, isCompare;
  logic trap, equal, greater, inExec, lastWord;
  logic [1:0] numOps;
  logic [2:0] cause;
  dest_e dest;
  logic hostStrobe;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic fmt_e idFormat(input logic [7:0] id);
    case (id)
      ID_FMT9: return FMT9;
      ID_FMT11: return FMT11;
      ID_FMT12: return FMT12;
      default: return FMT_BAD;
    endcase
  endfunction

  function automatic logic [1:0] wordsLast(input logic wide, input logic dbl);
    if (wide) begin
      return dbl ? 2'd1 : 2'd0;
    end
    return dbl ? 2'd3 : 2'd1;
  endfunction

  // wide doubles arrive high half first; narrow words arrive low first
  function automatic logic [63:0] placeWord(
    input logic [63:0] acc,
    input logic [1:0] idx,
    input logic [31:0] w,
    input logic wide,
    input logic dbl
  );
    logic [63:0] r;
    r = acc;
    if (wide) begin
      if (dbl && idx == 2'd0) begin
        r[63:32] = w;
      end else begin
        r[31:0] = w;
      end
    end else begin
      r[{idx, 4'h0} +: 16] = w[15:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus cycle decoding and execution units
  // ----------------------------------------------------------------
  // the device's own strobe pulse must not look like a host cycle
  assign hostStrobe = slaveStrobeIn || !strobeDriveN_q;

  bus_capture u_capture (
    .clk(clk),
    .rst(rst),
    .strobeIn(hostStrobe),
    .statusIn(busStatusCode),
    .dataIn(dataIn),
    .sampleAtT2(sampleAtT2),
    .t2State(t2State),
    .cyc(cyc.src)
  );

  fp_exec u_exec (
    .fmt(fmt_q),
    .opWord(opWord_q),
    .gen1(gen1_q),
    .gen2(gen2_q),
    .fp_status_register(fsr_q),
    .illegal(illegal),
    .numOps(numOps),
    .isDouble(isDouble),
    .isLoadStatus(isLoadStatus),
    .isStoreStatus(isStoreStatus),
    .isCompare(isCompare),
    .dest(dest),
    .cause(cause),
    .trap(trap),
    .equal(equal),
    .greater(greater)
  );

  assign inExec = (state_q == S_EXEC);
  assign lastWord = (wordIdx_q == wordsLast(wideProtocol, isDouble));

  // ----------------------------------------------------------------
  // instruction sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    fmt_d = fmt_q;
    opWord_d = opWord_q;
    gen1_d = gen1_q;
    gen2_d = gen2_q;
    opIdx_d = opIdx_q;
    wordIdx_d = wordIdx_q;
    resIdx_d = resIdx_q;
    fsr_d = fsr_q;
    ssw_d = ssw_q;
    dest_d = dest_q;
    case (state_q)
      S_IDLE: begin
        state_d = S_IDLE;
      end
      S_OPWORD: begin
        if (cyc.finish && cyc.status == ST_OP) begin
          opWord_d = {cyc.data[7:0], cyc.data[15:8]};
          state_d = S_DECODE;
        end
      end
      S_DECODE: begin
        opIdx_d = 1'b0;
        wordIdx_d = 2'd0;
        gen1_d = 64'h0;
        gen2_d = 64'h0;
        state_d = (numOps == 2'd0) ? S_EXEC : S_OPERANDS;
      end
      S_OPERANDS: begin
        if (cyc.finish && cyc.status == ST_OP) begin
          if (!opIdx_q) begin
            gen1_d = placeWord(gen1_q, wordIdx_q, cyc.data, wideProtocol, isDouble);
          end else begin
            gen2_d = placeWord(gen2_q, wordIdx_q, cyc.data, wideProtocol, isDouble);
          end
          wordIdx_d = wordIdx_q + 2'd1;
          if (lastWord) begin
            wordIdx_d = 2'd0;
            opIdx_d = 1'b1;
            if (opIdx_q || numOps == 2'd1) begin
              state_d = S_EXEC;
            end
          end
        end
      end
      S_EXEC: begin
        // underflow and inexact are always reported, trapped or not
        if (cause == TT_UNDERFLOW) begin
          fsr_d[FSR_UF] = 1'b1;
        end
        if (cause == TT_INEXACT) begin
          fsr_d[FSR_IF] = 1'b1;
        end
        if (trap) begin
          ssw_d[SSW_TRAP] = 1'b1;
          ssw_d[SSW_UNDEF] = illegal;
          fsr_d[FSR_TT_LSB +: 3] = cause;
          dest_d = DEST_NONE;
          state_d = S_IDLE;
        end else begin
          dest_d = dest;
          if (isLoadStatus) begin
            fsr_d = gen1_q[31:0];
          end else if (!isStoreStatus) begin
            fsr_d[FSR_TT_LSB +: 3] = cause;
          end
          if (dest == DEST_ACC_SINGLE || dest == DEST_ACC_DOUBLE) begin
            fsr_d[FSR_RMB] = 1'b1;
          end
          if (isCompare) begin
            ssw_d[SSW_EQUAL] = equal;
            ssw_d[SSW_GREATER] = greater;
            ssw_d[SSW_THIRD] = 1'b0;
          end
          state_d = isStoreStatus ? S_RESULT : S_IDLE;
        end
      end
      S_RESULT: begin
        if (cyc.finish && cyc.status == ST_OP) begin
          resIdx_d = 1'b1;
          if (wideProtocol || resIdx_q) begin
            state_d = S_IDLE;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    // an id broadcast always restarts, so an aborted instruction can be retried
    if (cyc.finish && cyc.status == ST_ID) begin
      ssw_d = 8'h00;
      resIdx_d = 1'b0;
      if (wideProtocol) begin
        fmt_d = idFormat(cyc.data[31:24]);
        opWord_d = {cyc.data[15:8], cyc.data[23:16]};
        state_d = S_DECODE;
      end else begin
        fmt_d = idFormat(cyc.data[7:0]);
        state_d = S_OPWORD;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      fmt_q <= FMT_BAD;
      opWord_q <= 16'h0000;
      gen1_q <= 64'h0;
      gen2_q <= 64'h0;
      opIdx_q <= 1'b0;
      wordIdx_q <= 2'd0;
      resIdx_q <= 1'b0;
      fsr_q <= FSR_RESET;
      ssw_q <= 8'h00;
      dest_q <= DEST_NONE;
    end else begin
      state_q <= state_d;
      fmt_q <= fmt_d;
      opWord_q <= opWord_d;
      gen1_q <= gen1_d;
      gen2_q <= gen2_d;
      opIdx_q <= opIdx_d;
      wordIdx_q <= wordIdx_d;
      resIdx_q <= resIdx_d;
      fsr_q <= fsr_d;
      ssw_q <= ssw_d;
      dest_q <= dest_d;
    end
  end

  // ----------------------------------------------------------------
  // pins: completion pulses, read data, power down
  // ----------------------------------------------------------------
  always_comb begin
    // narrow hosts hear completion on the strobe, traps use it on both
    strobeDriveN_d = !(inExec && (trap || !wideProtocol));
    strobeOut_d = strobeDriveN_d;
    if (inExec) begin
      if (trap) begin
        doneCnt_d = DONE_TRAP_CLOCKS;
      end else begin
        doneCnt_d = wideProtocol ? DONE_OK_CLOCKS : 2'd0;
      end
    end else begin
      doneCnt_d = (doneCnt_q != 2'd0) ? doneCnt_q - 2'd1 : 2'd0;
    end
    doneB_d = (doneCnt_d == 2'd0);
    status_read_request_d = inExec && (trap || (wideProtocol && isCompare));
    dataOut_d = dataOut_q;
    dataDriveN_d = dataDriveN_q;
    if (cyc.start && cyc.status == ST_STATUS) begin
      dataOut_d = {24'h000000, ssw_q};
      dataDriveN_d = 1'b0;
    end else if (cyc.start && cyc.status == ST_OP && state_q == S_RESULT) begin
      if (wideProtocol) begin
        dataOut_d = fsr_q;
      end else begin
        dataOut_d = {16'h0000, resIdx_q ? fsr_q[31:16] : fsr_q[15:0]};
      end
      dataDriveN_d = 1'b0;
    end
    if (!cyc.strobeLow) begin
      dataDriveN_d = 1'b1;
    end
    // the sequence never waits on this, so waking costs nothing
    if (cyc.start) begin
      idle_d = 8'h00;
      stopped_d = 1'b0;
    end else begin
      idle_d = (idle_q == IDLE_LAST) ? idle_q : idle_q + 8'h01;
      stopped_d = stopped_q || (idle_q == IDLE_LAST);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeOut_q <= 1'b1;
      strobeDriveN_q <= 1'b1;
      dataOut_q <= 32'h0000_0000;
      dataDriveN_q <= 1'b1;
      doneCnt_q <= 2'd0;
      doneB_q <= 1'b1;
      status_read_request_q <= 1'b0;
      idle_q <= 8'h00;
      stopped_q <= 1'b0;
    end else begin
      strobeOut_q <= strobeOut_d;
      strobeDriveN_q <= strobeDriveN_d;
      dataOut_q <= dataOut_d;
      dataDriveN_q <= dataDriveN_d;
      doneCnt_q <= doneCnt_d;
      doneB_q <= doneB_d;
      status_read_request_q <= status_read_request_d;
      idle_q <= idle_d;
      stopped_q <= stopped_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign slaveStrobeOut = strobeOut_q;
  assign slaveStrobeDriveN = strobeDriveN_q;
  assign dataOut = dataOut_q;
  assign dataDriveN = dataDriveN_q;
  assign doneStrobeB = doneB_q;
  assign statusReadRequest = status_read_request_q;
  assign clocksStopped = stopped_q;
  assign roundMode = fsr_q[FSR_RM_LSB +: 2];
  assign resultDest = dest_q;

endmodule
`default_nettype wire

// >>> pkg/fp_port_pkg.sv
// Purpose: shared constants and types for the floating-point slave port
// Assumes: one 50 MHz clock, async active-high reset
// Notes: opcode word, id byte and slave status word layouts are local choices
//
// How it works
// - three-field format decodes divide, negate, absolute
// - extended format decodes scale, exponent, dot, poly
// - dot and poly target single or double accumulator
// - compare sets equal, greater; clears third flag
// - status register loaded and stored as word
// - four rounding modes held in status register
// - five exceptions; underflow, inexact maskable; illegal traps
// - trap pulses strobe, done strobe, status request
// - trap sets flag; host reads status word
// - trapped instruction delivers nothing; cause recorded
// - illegal opcode sets undefined trap flag
// - 256 idle clocks stop internal clocks
// - strobe wakes device with no added latency
// - reset aborts work and clears status register
// - host strobes each transfer; device tracks status
// - status sampled at strobe fall or T2
// - read data driven while strobe is low
// - write data captured at strobe rising edge
// - narrow bus: low word first, bytes on D0-D7
// - wide bus: double sends high half first
// - status tracking lets host retry aborted instruction
// - cause field uses three-bit exception code
`default_nettype none
package fp_port_pkg;
  localparam logic [3:0] ST_ID = 4'hF;
  localparam logic [3:0] ST_OP = 4'hD;
  localparam logic [3:0] ST_STATUS = 4'hE;
  // id byte codes: values arbitrary
  localparam logic [7:0] ID_FMT9 = 8'h01;
  localparam logic [7:0] ID_FMT11 = 8'h02;
  localparam logic [7:0] ID_FMT12 = 8'h03;
  localparam int OPW_F = 0;
  localparam int OPW_OP_LSB = 2;
  localparam int OPW_OP9_LSB = 3;
  localparam logic [3:0] OP11_ADD = 4'h0;
  localparam logic [3:0] OP11_MOV = 4'h1;
  localparam logic [3:0] OP11_CMP = 4'h2;
  localparam logic [3:0] OP11_SUB = 4'h4;
  localparam logic [3:0] OP11_NEG = 4'h5;
  localparam logic [3:0] OP11_DIV = 4'h8;
  localparam logic [3:0] OP11_MUL = 4'hC;
  localparam logic [3:0] OP11_ABS = 4'hD;
  localparam logic [3:0] OP12_POLY = 4'h2;
  localparam logic [3:0] OP12_DOT = 4'h3;
  localparam logic [3:0] OP12_SCALE_BY_POW2_OP = 4'h4;
  localparam logic [3:0] OP12_LOGB = 4'h5;
  localparam logic [2:0] OP9_LOAD_STATUS_INSTR = 3'h1;
  localparam logic [2:0] OP9_STORE_STATUS_INSTR = 3'h6;
  localparam logic [2:0] TT_NONE = 3'h0;
  localparam logic [2:0] TT_UNDERFLOW = 3'h1;
  localparam logic [2:0] TT_OVERFLOW = 3'h2;
  localparam logic [2:0] TT_DIVZERO = 3'h3;
  localparam logic [2:0] TT_ILLEGAL = 3'h4;
  localparam logic [2:0] TT_INVALID = 3'h5;
  localparam logic [2:0] TT_INEXACT = 3'h6;
  localparam int FSR_TT_LSB = 0;
  localparam int FSR_UEN = 3;
  localparam int FSR_UF = 4;
  localparam int FSR_IEN = 5;
  localparam int FSR_IF = 6;
  localparam int FSR_RM_LSB = 7;
  localparam int FSR_RMB = 16;
  localparam logic [31:0] FSR_RESET = 32'h0000_0000;
  localparam int SSW_TRAP = 0;
  localparam int SSW_UNDEF = 1;
  localparam int SSW_THIRD = 2;
  localparam int SSW_EQUAL = 6;
  localparam int SSW_GREATER = 7;
  localparam int POWER_DOWN_CLOCKS = 256;
  localparam logic [7:0] IDLE_LAST = 8'(POWER_DOWN_CLOCKS - 1);
  localparam int DONE_TRAP_HALF_CLOCKS = 5;
  localparam logic [1:0] DONE_TRAP_CLOCKS = 2'((DONE_TRAP_HALF_CLOCKS + 1) / 2);
  localparam logic [1:0] DONE_OK_CLOCKS = 2'h1;
  localparam int RESET_MIN_CLOCKS = 64;
  typedef enum logic [1:0] {
    RM_NEAREST = 2'b00, RM_ZERO = 2'b01, RM_POS_INF = 2'b10, RM_NEG_INF = 2'b11
  } round_e;
  typedef enum logic [1:0] {
    FMT9 = 2'b00, FMT11 = 2'b01, FMT12 = 2'b10, FMT_BAD = 2'b11
  } fmt_e;
  typedef enum logic [1:0] {
    DEST_GEN2 = 2'b00, DEST_ACC_SINGLE = 2'b01, DEST_ACC_DOUBLE = 2'b10, DEST_NONE = 2'b11
  } dest_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_OPWORD = 3'b001, S_DECODE = 3'b010,
    S_OPERANDS = 3'b011, S_EXEC = 3'b100, S_RESULT = 3'b101
  } seq_e;
endpackage
`default_nettype wire

// >>> pkg/slave_cycle_if.sv
// Purpose: one host bus cycle as seen after strobe decoding
// Assumes: all signals in the clk domain
// Notes: start and finish are single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface slave_cycle_if;
  logic start;
  logic finish;
  logic strobeLow;
  logic [3:0] status;
  logic [31:0] data;
  modport src(output start, finish, strobeLow, status, data);
  modport dst(input start, finish, strobeLow, status, data);
endinterface
`default_nettype wire

// >>> tb/fp_port_chk.sv
// Purpose: port-level checks of the floating-point slave port
// Assumes: one clock, async reset, status sampled at strobe fall
// Notes: idle counter bounds allow two edges of slack either side
`timescale 1ns/1ps
`default_nettype none
module fp_port_chk
  import fp_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slaveStrobeIn,
  input wire logic slaveStrobeOut,
  input wire logic slaveStrobeDriveN,
  input wire logic [3:0] busStatusCode,
  input wire logic dataDriveN,
  input wire logic doneStrobeB,
  input wire logic statusReadRequest,
  input wire logic wideProtocol,
  input wire logic sampleAtT2,
  input wire logic clocksStopped
);
  logic prev_q;
  logic [8:0] idle_q;
  logic [8:0] idle_d;
  logic start;
  // the device's own strobe pulse is not a host start
  assign start = prev_q && !slaveStrobeIn && slaveStrobeDriveN;
  always_comb begin
    idle_d = idle_q;
    if (start) begin
      idle_d = 9'h000;
    end else if (idle_q != 9'h1FF) begin
      idle_d = idle_q + 9'h001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
      idle_q <= 9'h000;
    end else begin
      prev_q <= slaveStrobeIn;
      idle_q <= idle_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_trap_done: assert property (
    $fell(slaveStrobeDriveN) && wideProtocol |-> !doneStrobeB [*3] ##1 doneStrobeB)
    else $error("done strobe length wrong on trap");
  a_strobe_pulse: assert property (!slaveStrobeDriveN |=> slaveStrobeDriveN)
    else $error("strobe pulse longer than one clock");
  a_strobe_low: assert property (!slaveStrobeDriveN |-> !slaveStrobeOut)
    else $error("driven strobe not low");
  a_req_pulse: assert property (statusReadRequest |=> !statusReadRequest)
    else $error("status request longer than one clock");
  a_req_done: assert property (statusReadRequest |-> !doneStrobeB)
    else $error("status request without done strobe");
  a_read_start: assert property (
    $fell(slaveStrobeIn) && slaveStrobeDriveN && !sampleAtT2
    && busStatusCode == ST_STATUS |=> !dataDriveN)
    else $error("status read not driven");
  a_read_hold: assert property (!dataDriveN && !slaveStrobeIn |=> !dataDriveN)
    else $error("read data dropped while strobe low");
  a_read_end: assert property (!dataDriveN && slaveStrobeIn |=> dataDriveN)
    else $error("read data held after strobe rise");
  a_wake_fast: assert property (start |=> ##[0:1] !clocksStopped)
    else $error("no wake after strobe");
  a_idle_run: assert property (idle_q == 9'h0FD |-> !clocksStopped)
    else $error("clocks stopped too early");
  a_idle_stop: assert property (idle_q == 9'h102 |-> clocksStopped)
    else $error("clocks not stopped after idle");
endmodule
`default_nettype wire

// >>> tb/fp_slave_coprocessor_port_tb_top.sv
// Purpose: self-checking bench of the floating-point slave port
// Assumes: 32-bit protocol, status sampled at strobe fall
// Notes: wire levels of strobe and data resolved from both enables
`timescale 1ns/1ps
`default_nettype none
module fp_slave_coprocessor_port_tb_top
  import fp_port_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hostSpc, spcWire, sOut, sDrvN, dDrvN, doneB, req, stopped;
  logic [3:0] st;
  logic [31:0] hostData, dataBus, dOut, d;
  logic [1:0] rm, dest;
  int fail_count = 0;
  int n_checks = 0;
  localparam logic [15:0] LOAD_STATUS_INSTR = {10'h000, OP9_LOAD_STATUS_INSTR, 3'h0};
  localparam logic [15:0] STORE_STATUS_INSTR = {10'h000, OP9_STORE_STATUS_INSTR, 3'h0};
  localparam logic [15:0] CMP = {10'h000, OP11_CMP, 2'h1};
  localparam logic [15:0] DIV = {10'h000, OP11_DIV, 2'h1};
  always #10 clk = ~clk;
  assign spcWire = sDrvN ? hostSpc : sOut;
  assign dataBus = dDrvN ? hostData : dOut;
  host_model i_host(.clk(clk), .slave_strobe(hostSpc), .st(st), .data(hostData), .bus(dataBus));
  fp_slave_coprocessor_port i_dut(.clk(clk), .rst(rst), .slaveStrobeIn(spcWire),
    .slaveStrobeOut(sOut), .slaveStrobeDriveN(sDrvN), .busStatusCode(st),
    .dataIn(dataBus), .dataOut(dOut), .dataDriveN(dDrvN), .doneStrobeB(doneB),
    .statusReadRequest(req), .wideProtocol(1'b1), .sampleAtT2(1'b0), .t2State(1'b0),
    .clocksStopped(stopped), .roundMode(rm), .resultDest(dest));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task run(input logic [7:0] id, input logic [15:0] w, input int n,
           input logic [31:0] a, input logic [31:0] b);
    int k;
    i_host.wr(ST_ID, {id, w[7:0], w[15:8], 8'h00});
    if (n > 0) i_host.wr(ST_OP, a);
    if (n > 1) i_host.wr(ST_OP, b);
    k = 0;
    while (doneB !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 50), 32'h1);
    // let the device strobe pulse end before the next cycle
    repeat (4) @(posedge clk);
  endtask
  task store_fsr;
    run(ID_FMT9, STORE_STATUS_INSTR, 0, 32'h0, 32'h0);
    i_host.rd(ST_STATUS, d);
    i_host.rd(ST_OP, d);
  endtask
  task t_fsr;
    for (int m = 0; m < 4; m++) begin
      run(ID_FMT9, LOAD_STATUS_INSTR, 1, 32'(m) << 7, 32'h0);
      chk(32'(rm), 32'(m));
      store_fsr;
      chk(d, 32'(m) << 7);
    end
    $display("test fsr done");
  endtask
  task t_cmp(input logic [31:0] a, input logic [7:0] sw);
    run(ID_FMT11, CMP, 2, a, 32'h0);
    i_host.rd(ST_STATUS, d);
    chk(32'(d[7:0]), 32'(sw));
    $display("test compare done");
  endtask
  task t_trap(input logic [7:0] id, input logic [15:0] w, input int n,
              input logic [31:0] a, input logic [7:0] sw, input logic [2:0] tt);
    run(id, w, n, a, 32'h3F80_0000);
    chk(32'(dest), 32'h3);
    i_host.rd(ST_STATUS, d);
    chk(32'(d[7:0]), 32'(sw));
    store_fsr;
    chk(32'(d[2:0]), 32'(tt));
    $display("test trap done");
  endtask
  task t_reset;
    run(ID_FMT9, LOAD_STATUS_INSTR, 1, 32'h0000_0100, 32'h0);
    rst <= 1'b1;
    repeat (64) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({rm, dest, doneB, req, stopped}), 32'h1C);
    store_fsr;
    chk(d, FSR_RESET);
    $display("test reset done");
  endtask
  task t_power;
    repeat (300) @(posedge clk);
    chk(32'(stopped), 32'h1);
    t_cmp(32'h8000_0000, 8'h40);
    chk(32'(stopped), 32'h0);
    $display("test power done");
  endtask
  task t_dest(input logic [7:0] id, input logic [15:0] w, input logic [1:0] e);
    run(id, w, 2, 32'h0, 32'h0);
    chk(32'(dest), 32'(e));
    $display("test dest done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({rm, dest, doneB, req, stopped}), 32'h1C);
    t_fsr;
    t_cmp(32'h8000_0000, 8'h40);
    t_cmp(32'h3F80_0000, 8'h80);
    t_dest(ID_FMT12, {10'h000, OP12_DOT, 2'h1}, DEST_ACC_SINGLE);
    t_dest(ID_FMT11, {10'h000, OP11_ABS, 2'h0}, DEST_GEN2);
    t_trap(8'h7E, 16'h0000, 0, 32'h0, 8'h03, TT_ILLEGAL);
    t_trap(ID_FMT11, DIV, 2, 32'h0, 8'h01, TT_DIVZERO);
    t_reset;
    t_power;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule
bind fp_slave_coprocessor_port fp_port_chk i_chk(.clk(clk), .rst(rst),
  .slaveStrobeIn(slaveStrobeIn), .slaveStrobeOut(slaveStrobeOut),
  .slaveStrobeDriveN(slaveStrobeDriveN), .busStatusCode(busStatusCode),
  .dataDriveN(dataDriveN), .doneStrobeB(doneStrobeB),
  .statusReadRequest(statusReadRequest), .wideProtocol(wideProtocol),
  .sampleAtT2(sampleAtT2), .clocksStopped(clocksStopped));
`default_nettype wire

// >>> tb/host_model.sv
// Purpose: host side of the slave bus cycles
// Assumes: strobe and data resolved by the bench
// Notes: released data shows the inverse so stale values never match
`timescale 1ns/1ps
`default_nettype none
module host_model
  import fp_port_pkg::*;
(
  input wire logic clk,
  output logic slave_strobe,
  output logic [3:0] st,
  output logic [31:0] data,
  input wire logic [31:0] bus
);
  initial begin
    slave_strobe = 1'b1;
    st = 4'h0;
    data = 32'h0;
  end
  task wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    slave_strobe <= 1'b0;
    st <= s;
    data <= d;
    @(posedge clk);
    slave_strobe <= 1'b1;
    @(posedge clk);
    data <= ~d;
  endtask
  task rd(input logic [3:0] s, output logic [31:0] d);
    @(posedge clk);
    slave_strobe <= 1'b0;
    st <= s;
    @(posedge clk);
    @(posedge clk);
    d = bus;
    slave_strobe <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire
